// *** core/ztmd_map.svh ***
// register map, field positions, reset values and timing counts for the zero tracking block
// assumes a 32-bit apb master and a 250 MHz pclk
`ifndef ZTMD_MAP_SVH
`define ZTMD_MAP_SVH

`define ZTMD_A_CTRL      12'h000
`define ZTMD_A_ZBAND     12'h004
`define ZTMD_A_ZINT      12'h008
`define ZTMD_A_MBAND     12'h00C
`define ZTMD_A_MPER      12'h010
`define ZTMD_A_DIV       12'h014
`define ZTMD_A_ZERO      12'h018
`define ZTMD_A_STATUS    12'h01C
`define ZTMD_A_NET       12'h020
`define ZTMD_A_IRQ_STAT  12'h024
`define ZTMD_A_IRQ_MASK  12'h028

`define ZTMD_CTRL_AZT    0
`define ZTMD_CTRL_MOT    1
`define ZTMD_CTRL_PUZ    2

`define ZTMD_EV_STABLE   0
`define ZTMD_EV_MOTION   1
`define ZTMD_EV_TRACK    2
`define ZTMD_EV_REJECT   3
`define ZTMD_EV_REFUSE   4

`define ZTMD_RST_CTRL    3'h2
`define ZTMD_RST_BAND    8'h01
`define ZTMD_RST_MS      14'h03E8
`define ZTMD_RST_DIV     16'h0001
`define ZTMD_MS_MIN      14'h0032
`define ZTMD_MS_MAX      14'h2710

`define ZTMD_TICK_NS     1000000
`define ZTMD_CLK_NS      4
`define ZTMD_MS_CYCLES   (`ZTMD_TICK_NS / `ZTMD_CLK_NS)

`endif

// *** core/ztmd_pkg.sv ***
// types shared by the zero tracking and motion detection block
// assumes ztmd_map.svh for all numbers
package ztmd_pkg;
    typedef logic signed [23:0] ztmd_weight_t;
    typedef logic        [13:0] ztmd_ms_t;
    typedef logic        [4:0]  ztmd_ev_t;
    typedef enum logic { ZTMD_SETTLING, ZTMD_STEADY } ztmd_mstate_t;
endpackage

// *** core/ztmd_top.sv ***
// zero tracking and motion detection for one weighing channel, apb register slave
// assumes readings and requests arrive synchronous to pclk from the converter and tare logic
//
// Design decisions made here: the address map and the APB register port.
`include "ztmd_map.svh"

module ztmd_top
    import ztmd_pkg::*;
#(
    parameter int unsigned MS_CYCLES = `ZTMD_MS_CYCLES
)
(
    input  wire logic         pclk,
    input  wire logic         presetn,
    input  wire logic         psel,
    input  wire logic         penable,
    input  wire logic         pwrite,
    input  wire logic [11:0]  paddr,
    input  wire logic [31:0]  pwdata,
    output logic      [31:0]  prdata,
    output logic              pready,
    output logic              pslverr,
    input  wire logic         sample_valid,
    input  wire ztmd_weight_t sample_gross,
    input  wire logic         tare_req,
    input  wire logic         zero_req,
    input  wire logic         total_req,
    output logic              tare_ack,
    output logic              zero_ack,
    output logic              total_ack,
    output logic              req_refused,
    output ztmd_weight_t      zero_offset,
    output logic              stable,
    output logic              irq
);

    // band check in half divisions: code 0 is half a division, else code divisions
    function automatic logic in_band(input ztmd_weight_t a, input ztmd_weight_t b,
                                     input logic [7:0] code, input logic [15:0] div);
        logic signed [24:0] diff;
        logic        [24:0] mag;
        logic        [25:0] lim;
        diff = 25'(a) - 25'(b);
        mag  = diff[24] ? 25'(-diff) : 25'(diff);
        if (code == 8'h00)
            lim = {10'h000, div};
        else
            lim = {1'b0, 24'(div) * 24'(code), 1'b0};   // full 24-bit product, no wrap at high codes
        return {mag, 1'b0} <= lim;
    endfunction

    function automatic logic ms_ok(input logic [31:0] v);
        return (v[31:14] == 18'h00000) && (v[13:0] >= `ZTMD_MS_MIN) && (v[13:0] <= `ZTMD_MS_MAX);
    endfunction

    logic [2:0]   ctrl_q,  ctrl_d;
    logic [7:0]   zband_q, zband_d;
    logic [7:0]   mband_q, mband_d;
    ztmd_ms_t     zint_q,  zint_d;
    ztmd_ms_t     mper_q,  mper_d;
    logic [15:0]  div_q,   div_d;
    ztmd_ev_t     ist_q,   ist_d;
    ztmd_ev_t     mask_q,  mask_d;
    logic [31:0]  prdata_q, prdata_d;
    logic         pready_q, pready_d;
    logic         pslverr_q, pslverr_d;
    logic         irq_q,   irq_d;
    logic         wr_en;
    logic         zero_wr;
    logic         ev_reject;
    ztmd_ev_t     events;

    logic [17:0]  tick_cnt_q, tick_cnt_d;
    logic         tick;

    ztmd_mstate_t mst_q,   mst_d;
    ztmd_weight_t ref_q,   ref_d;
    ztmd_ms_t     mcnt_q,  mcnt_d;
    logic         ev_stable;
    logic         ev_motion;

    ztmd_weight_t zero_q,  zero_d;
    ztmd_weight_t last_q,  last_d;
    logic         first_q, first_d;
    logic         chk_q,   chk_d;
    ztmd_ms_t     acnt_q,  acnt_d;
    logic         ev_track;

    logic         tare_ack_q,  tare_ack_d;
    logic         zero_ack_q,  zero_ack_d;
    logic         total_ack_q, total_ack_d;
    logic         refused_q,   refused_d;

    // one wait state: pready rises one cycle into the access phase
    assign wr_en   = psel & penable & pready_q & pwrite;
    assign zero_wr = wr_en & (paddr == `ZTMD_A_ZERO);

    // configuration, interrupt and bus answer next state
    always_comb
    begin
        ctrl_d    = ctrl_q;
        zband_d   = zband_q;
        mband_d   = mband_q;
        zint_d    = zint_q;
        mper_d    = mper_q;
        div_d     = div_q;
        mask_d    = mask_q;
        ev_reject = 1'b0;
        prdata_d  = prdata_q;
        pready_d  = psel & penable & ~pready_q;
        pslverr_d = 1'b0;
        if (wr_en)
        begin
            unique case (paddr)
                `ZTMD_A_CTRL:     ctrl_d  = pwdata[2:0];
                `ZTMD_A_ZBAND:    zband_d = pwdata[7:0];
                `ZTMD_A_MBAND:    mband_d = pwdata[7:0];
                `ZTMD_A_DIV:      div_d   = pwdata[15:0];
                `ZTMD_A_IRQ_MASK: mask_d  = pwdata[4:0];
                `ZTMD_A_ZINT:
                begin
                    if (ms_ok(pwdata))
                        zint_d = pwdata[13:0];
                    else
                        ev_reject = 1'b1;
                end
                `ZTMD_A_MPER:
                begin
                    if (ms_ok(pwdata))
                        mper_d = pwdata[13:0];
                    else
                        ev_reject = 1'b1;
                end
                default: ;
            endcase
        end
        if (psel & penable & ~pready_q)
        begin
            prdata_d = 32'h0000_0000;
            unique case (paddr)
                `ZTMD_A_CTRL:     prdata_d = {29'h0, ctrl_q};
                `ZTMD_A_ZBAND:    prdata_d = {24'h0, zband_q};
                `ZTMD_A_ZINT:     prdata_d = {18'h0, zint_q};
                `ZTMD_A_MBAND:    prdata_d = {24'h0, mband_q};
                `ZTMD_A_MPER:     prdata_d = {18'h0, mper_q};
                `ZTMD_A_DIV:      prdata_d = {16'h0, div_q};
                `ZTMD_A_ZERO:     prdata_d = 32'(zero_q);
                `ZTMD_A_STATUS:   prdata_d = {29'h0, chk_q, first_q, mst_q == ZTMD_STEADY};
                `ZTMD_A_NET:      prdata_d = 32'(signed'(last_q) - signed'(zero_q));
                `ZTMD_A_IRQ_STAT: prdata_d = {27'h0, ist_q};
                `ZTMD_A_IRQ_MASK: prdata_d = {27'h0, mask_q};
                default:          pslverr_d = 1'b1;
            endcase
            if (pwrite)
                prdata_d = prdata_q;
            if (pwrite & (paddr > `ZTMD_A_IRQ_MASK))
                pslverr_d = 1'b1;
        end
        // set wins over a write-one clear in the same cycle
        ist_d = ist_q & ~((wr_en & (paddr == `ZTMD_A_IRQ_STAT)) ? pwdata[4:0] : 5'h00);
        ist_d = ist_d | events;
        irq_d = |(ist_d & mask_d);
    end

    assign events = {refused_d, ev_reject, ev_track, ev_motion, ev_stable};

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ctrl_q    <= `ZTMD_RST_CTRL;
            zband_q   <= `ZTMD_RST_BAND;
            mband_q   <= `ZTMD_RST_BAND;
            zint_q    <= `ZTMD_RST_MS;
            mper_q    <= `ZTMD_RST_MS;
            div_q     <= `ZTMD_RST_DIV;
            ist_q     <= 5'h00;
            mask_q    <= 5'h00;
            prdata_q  <= 32'h0000_0000;
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
            irq_q     <= 1'b0;
        end
        else
        begin
            ctrl_q    <= ctrl_d;
            zband_q   <= zband_d;
            mband_q   <= mband_d;
            zint_q    <= zint_d;
            mper_q    <= mper_d;
            div_q     <= div_d;
            ist_q     <= ist_d;
            mask_q    <= mask_d;
            prdata_q  <= prdata_d;
            pready_q  <= pready_d;
            pslverr_q <= pslverr_d;
            irq_q     <= irq_d;
        end
    end

    // millisecond time base shared by both timers
    always_comb
    begin
        tick       = (tick_cnt_q == 18'(MS_CYCLES - 1));
        tick_cnt_d = tick ? 18'h00000 : tick_cnt_q + 18'h00001;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            tick_cnt_q <= 18'h00000;
        else
            tick_cnt_q <= tick_cnt_d;
    end

    // motion detection: reference restarts at every excursion
    always_comb
    begin
        mst_d     = mst_q;
        ref_d     = ref_q;
        mcnt_d    = mcnt_q;
        ev_stable = 1'b0;
        ev_motion = 1'b0;
        if (!ctrl_q[`ZTMD_CTRL_MOT])
        begin
            mst_d  = ZTMD_STEADY;
            mcnt_d = 14'h0000;
            ref_d  = last_q;
        end
        else if (sample_valid && !in_band(sample_gross, ref_q, mband_q, div_q))
        begin
            mst_d  = ZTMD_SETTLING;
            ref_d  = sample_gross;
            mcnt_d = 14'h0000;
            ev_motion = (mst_q == ZTMD_STEADY);
        end
        else
        begin
            if (tick && (mcnt_q < mper_q))
                mcnt_d = mcnt_q + 14'h0001;
            unique case (mst_q)
                ZTMD_SETTLING: if (mcnt_q >= mper_q) mst_d = ZTMD_STEADY;
                ZTMD_STEADY:   ;
            endcase
        end
        ev_stable = (mst_d == ZTMD_STEADY) && (mst_q == ZTMD_SETTLING);
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            mst_q  <= ZTMD_SETTLING;
            ref_q  <= 24'h000000;
            mcnt_q <= 14'h0000;
        end
        else
        begin
            mst_q  <= mst_d;
            ref_q  <= ref_d;
            mcnt_q <= mcnt_d;
        end
    end

    // zero offset: power-up capture, periodic tracking, accepted zero requests
    always_comb
    begin
        zero_d   = zero_q;
        last_d   = sample_valid ? sample_gross : last_q;
        first_d  = first_q;
        chk_d    = chk_q;
        acnt_d   = acnt_q;
        ev_track = 1'b0;
        if (tick)
        begin
            if (acnt_q + 14'h0001 >= zint_q)
            begin
                acnt_d = 14'h0000;
                chk_d  = 1'b1;
            end
            else
                acnt_d = acnt_q + 14'h0001;
        end
        if (zero_wr)
            zero_d = pwdata[23:0];
        if (zero_req && (mst_q == ZTMD_STEADY))
            zero_d = last_q;
        if (sample_valid)
        begin
            if (first_q)
            begin
                first_d = 1'b0;
                if (ctrl_q[`ZTMD_CTRL_PUZ])
                    zero_d = sample_gross;
            end
            else if (chk_q)
            begin
                chk_d = 1'b0;
                // checks lapse silently while tracking is off
                if (ctrl_q[`ZTMD_CTRL_AZT] && in_band(sample_gross, zero_q, zband_q, div_q))
                begin
                    zero_d   = sample_gross;
                    ev_track = (sample_gross != zero_q);
                end
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            zero_q  <= 24'h000000;
            last_q  <= 24'h000000;
            first_q <= 1'b1;
            chk_q   <= 1'b0;
            acnt_q  <= 14'h0000;
        end
        else
        begin
            zero_q  <= zero_d;
            last_q  <= last_d;
            first_q <= first_d;
            chk_q   <= chk_d;
            acnt_q  <= acnt_d;
        end
    end

    // request gating: refusal rather than hold-off, so no stale request lingers
    always_comb
    begin
        tare_ack_d  = tare_req  & (mst_q == ZTMD_STEADY);
        zero_ack_d  = zero_req  & (mst_q == ZTMD_STEADY);
        total_ack_d = total_req & (mst_q == ZTMD_STEADY);
        refused_d   = (tare_req | zero_req | total_req) & (mst_q != ZTMD_STEADY);
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            tare_ack_q  <= 1'b0;
            zero_ack_q  <= 1'b0;
            total_ack_q <= 1'b0;
            refused_q   <= 1'b0;
        end
        else
        begin
            tare_ack_q  <= tare_ack_d;
            zero_ack_q  <= zero_ack_d;
            total_ack_q <= total_ack_d;
            refused_q   <= refused_d;
        end
    end

    // every output straight from a flop
    assign prdata      = prdata_q;
    assign pready      = pready_q;
    assign pslverr     = pslverr_q;
    assign tare_ack    = tare_ack_q;
    assign zero_ack    = zero_ack_q;
    assign total_ack   = total_ack_q;
    assign req_refused = refused_q;
    assign zero_offset = zero_q;
    assign stable      = (mst_q == ZTMD_STEADY);
    assign irq         = irq_q;

endmodule

// *** bench/ztmd_fe_model.sv ***
// front end model: converter readings and tare logic requests
// assumes the bench calls send and req; bus shows junk between readings
module ztmd_fe_model
    import ztmd_pkg::*;
(
    input  wire logic   pclk,
    output logic        sample_valid,
    output ztmd_weight_t sample_gross,
    output logic        tare_req,
    output logic        zero_req,
    output logic        total_req
);
    timeunit 1ns;
    timeprecision 100ps;

    // idle outputs from time zero
    initial
    begin
        sample_valid = 1'b0;
        sample_gross = 24'h0;
        {tare_req, zero_req, total_req} = 3'h0;
    end

    // one reading, then inverted data so stale values never look valid
    task automatic send(input ztmd_weight_t w);
        @(posedge pclk);
        sample_valid <= 1'b1;
        sample_gross <= w;
        @(posedge pclk);
        sample_valid <= 1'b0;
        sample_gross <= ~w;
    endtask

    // one-cycle request pulse: 0 tare, 1 zero, 2 total
    task automatic req(input int k);
        @(posedge pclk);
        tare_req  <= (k == 0);
        zero_req  <= (k == 1);
        total_req <= (k == 2);
        @(posedge pclk);
        {tare_req, zero_req, total_req} <= 3'h0;
    endtask
endmodule

// *** bench/ztmd_properties.sv ***
// port checker for ztmd_top, bound beside every instance
// assumes one pclk domain and presetn active low
module ztmd_checker
    import ztmd_pkg::*;
#(
    parameter int unsigned MS_CYCLES = 10
)
(
    input wire logic         pclk,
    input wire logic         presetn,
    input wire logic         psel,
    input wire logic         penable,
    input wire logic         pwrite,
    input wire logic         pready,
    input wire logic         pslverr,
    input wire logic         sample_valid,
    input wire ztmd_weight_t sample_gross,
    input wire logic         tare_req,
    input wire logic         zero_req,
    input wire logic         total_req,
    input wire logic         tare_ack,
    input wire logic         zero_ack,
    input wire logic         total_ack,
    input wire logic         req_refused,
    input wire ztmd_weight_t zero_offset,
    input wire logic         stable
);
    ztmd_weight_t last_q;
    ztmd_weight_t last_d;
    logic         any_req;
    logic         wr_done;

    // last reading seen, what a zero request must load
    always_comb last_d = sample_valid ? sample_gross : last_q;
    always_ff @(posedge pclk or negedge presetn)
        if (!presetn)
            last_q <= '0;
        else
            last_q <= last_d;
    // a config write may act one edge late, so allow two
    assign any_req = tare_req || zero_req || total_req;
    assign wr_done = pready && pwrite;

    default clocking @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    sequence s_setup;
        psel && !penable ##1 psel && penable;
    endsequence
    sequence s_answer;
        !pready ##1 pready;
    endsequence

    a_apb_answer: assert property (s_setup |-> s_answer)
        else $error("apb answer not in second access cycle");
    a_err_ready: assert property (pslverr |-> pready)
        else $error("pslverr without pready");
    a_refuse_unstable: assert property (
        any_req && !stable |=> req_refused && !(tare_ack || zero_ack || total_ack))
        else $error("request not refused while unstable");
    a_tare_cause: assert property (tare_ack |-> $past(tare_req) && $past(stable))
        else $error("tare ack without stable request");
    a_zero_accept: assert property (zero_req && stable |=> zero_ack && !req_refused)
        else $error("zero request not accepted while stable");
    a_total_accept: assert property (total_req && stable |=> total_ack)
        else $error("total request not accepted while stable");
    a_zero_loads: assert property (zero_req && stable && !sample_valid |=> zero_offset == last_q)
        else $error("zero request did not load last reading");
    a_offset_cause: assert property (
        $changed(zero_offset) |-> $past(sample_valid) || $past(zero_req) || $past(wr_done) || $past(wr_done, 2))
        else $error("zero offset changed without cause");
    a_stable_drop: assert property (
        $fell(stable) |-> $past(sample_valid) || $past(wr_done) || $past(wr_done, 2))
        else $error("stable fell without a reading");
endmodule

bind ztmd_top ztmd_checker #(.MS_CYCLES(MS_CYCLES)) u_chk (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .pready(pready),
    .pslverr(pslverr), .sample_valid(sample_valid), .sample_gross(sample_gross), .tare_req(tare_req),
    .zero_req(zero_req), .total_req(total_req), .tare_ack(tare_ack), .zero_ack(zero_ack),
    .total_ack(total_ack), .req_refused(req_refused), .zero_offset(zero_offset), .stable(stable));

// *** bench/tb_top.sv ***
// self-checking bench for ztmd_top with the front end model
// assumes MS_CYCLES of 10, so one ms is ten pclk cycles
`include "ztmd_map.svh"

module tb_top
    import ztmd_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;

    logic         pclk = 1'b0;
    logic         presetn, psel, penable, pwrite, pready, pslverr, irq, e;
    logic         sample_valid, tare_req, zero_req, total_req, tare_ack, zero_ack, total_ack, req_refused, stable;
    logic [11:0]  paddr;
    logic [31:0]  pwdata, prdata, r, v;
    logic [31:0]  seed = 32'hF0BC;
    logic [31:0]  cur [2];
    ztmd_weight_t sample_gross, zero_offset;
    int           error_cnt, cmp_count, cyc, n;
    logic [11:0]  ra [7] = '{`ZTMD_A_CTRL, `ZTMD_A_ZBAND, `ZTMD_A_ZINT, `ZTMD_A_MBAND, `ZTMD_A_MPER,
                             `ZTMD_A_DIV, `ZTMD_A_IRQ_MASK};
    logic [31:0]  rv [7] = '{`ZTMD_RST_CTRL, `ZTMD_RST_BAND, `ZTMD_RST_MS, `ZTMD_RST_BAND, `ZTMD_RST_MS,
                             `ZTMD_RST_DIV, 32'h0};
    logic [31:0]  lims [5] = '{32'd49, 32'd10001, 32'h4000_0032, 32'd10000, 32'd50};
    logic [11:0]  ta [2] = '{`ZTMD_A_ZINT, `ZTMD_A_MPER};

    ztmd_top #(.MS_CYCLES(10)) u_dut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .sample_valid(sample_valid),
        .sample_gross(sample_gross), .tare_req(tare_req), .zero_req(zero_req), .total_req(total_req),
        .tare_ack(tare_ack), .zero_ack(zero_ack), .total_ack(total_ack), .req_refused(req_refused),
        .zero_offset(zero_offset), .stable(stable), .irq(irq));
    ztmd_fe_model u_fe (.pclk(pclk), .sample_valid(sample_valid), .sample_gross(sample_gross),
        .tare_req(tare_req), .zero_req(zero_req), .total_req(total_req));

    initial
        forever #2 pclk = ~pclk;

    // watchdog: the run needs well under half this
    always @(posedge pclk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            error_cnt++;
            print_verdict();
        end
    end

    function automatic logic [31:0] rnd();
        seed = {seed[30:0], ^(seed & 32'h8020_0003)};
        return seed;
    endfunction

    function automatic logic [31:0] sext(input logic [23:0] w);
        return {{8{w[23]}}, w};
    endfunction

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("mismatch at %0t got %h expected %h", $time, got, exp);
        end
    endtask

    // one apb transfer, held until pready is sampled high
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rd(input logic [11:0] a, input logic [31:0] x, input logic xe = 1'b0);
        apb(1'b0, a, 32'h0);
        chk(r, x);
        chk(e, xe);
    endtask

    task automatic feed(input ztmd_weight_t w, input int k);
        repeat (k)
        begin
            u_fe.send(w);
            repeat (8) @(posedge pclk);
        end
        #1;
    endtask

    // noisy steady load until stable, n counts 10-cycle steps
    task automatic settle();
        n = 0;
        while (stable !== 1'b1 && n < 90)
        begin
            u_fe.send(ztmd_weight_t'(100 + rnd() % 2));
            repeat (8) @(posedge pclk);
            #1;
            n++;
        end
    endtask

    task automatic print_verdict();
        $display("compares %0d errors %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    initial
    begin
        {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        foreach (ra[i]) rd(ra[i], rv[i]);
        rd(12'h100, 32'h0, 1'b1);
        chk(stable, 1'b0);
        // random offsets come back sign-extended
        repeat (3)
        begin
            v = rnd();
            apb(1'b1, `ZTMD_A_ZERO, v);
            rd(`ZTMD_A_ZERO, sext(v[23:0]));
        end
        // interval limits on both timers, rejects flag an interrupt
        cur = '{32'd1000, 32'd1000};
        foreach (lims[i])
            for (int k = 0; k < 2; k++)
            begin
                apb(1'b1, ta[k], lims[i]);
                if (lims[i] >= 50 && lims[i] <= 10000)
                    cur[k] = lims[i];
                rd(ta[k], cur[k]);
            end
        chk(irq, 1'b0);
        apb(1'b1, `ZTMD_A_IRQ_MASK, 32'h8);
        repeat (2) @(posedge pclk);
        #1;
        chk(irq, 1'b1);
        apb(1'b1, `ZTMD_A_IRQ_STAT, 32'h8);
        repeat (2) @(posedge pclk);
        #1;
        chk(irq, 1'b0);
        apb(1'b1, `ZTMD_A_DIV, 32'h4);
        apb(1'b1, `ZTMD_A_MBAND, 32'h0);
        apb(1'b1, `ZTMD_A_CTRL, 32'h6);
        feed(24'sd7, 1);
        chk(zero_offset, 32'd7);
        u_fe.req(0);
        #1;
        chk({req_refused, tare_ack}, 32'h2);
        settle();
        chk(n >= 49 && n <= 53, 1'b1);
        u_fe.req(0);
        #1;
        chk({req_refused, tare_ack}, 32'h1);
        u_fe.req(2);
        #1;
        chk(total_ack, 1'b1);
        feed(24'sd102, 1);
        chk(stable, 1'b1);
        feed(24'sd105, 1);
        chk(stable, 1'b0);
        settle();
        chk(n >= 49 && n <= 53, 1'b1);
        apb(1'b1, `ZTMD_A_MBAND, 32'h1);
        feed(24'sd104, 1);
        chk(stable, 1'b1);
        // tracking: half division, then one division, then disabled
        apb(1'b1, `ZTMD_A_ZBAND, 32'h0);
        apb(1'b1, `ZTMD_A_CTRL, 32'h3);
        feed(24'sd9, 60);
        chk(zero_offset, 32'd9);
        feed(24'sd12, 60);
        chk(zero_offset, 32'd9);
        apb(1'b1, `ZTMD_A_ZBAND, 32'h1);
        feed(24'sd13, 60);
        chk(zero_offset, 32'd13);
        apb(1'b1, `ZTMD_A_CTRL, 32'h2);
        feed(24'sd14, 60);
        chk(zero_offset, 32'd13);
        rd(`ZTMD_A_NET, 32'h1);
        apb(1'b1, `ZTMD_A_CTRL, 32'h0);
        repeat (2) @(posedge pclk);
        #1;
        chk(stable, 1'b1);
        u_fe.req(1);
        #1;
        chk({zero_ack, zero_offset}, {8'h1, 24'd14});
        print_verdict();
    end
endmodule
